// ==== flash_protect_function_reg_tb.sv ====
// Self-checking bench: host end and device end joined over the serial link
module flash_protect_function_reg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic cmd_addr_en = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_data_en = 1'b0;
  logic cmd_quad = 1'b0;
  logic cmd_read = 1'b0;
  logic wp_level = 1'b1;
  logic cmd_ready, done, op_start, op_kind, op_refused, op_done, last_kind;
  logic [7:0] rdata, status_reg, func_reg;
  logic [7:0] sr_m = 8'h00;
  logic [7:0] fr_m = 8'h00;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_st = 0;
  int n_rf = 0;
  int n_dn = 0;
  int e_st = 0;
  int e_rf = 0;
  int seed = 32'h5841;

  fpr_if lnk ();
  fpr_host #(.HALF(4)) i_fpr_host (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_addr_en(cmd_addr_en),
    .cmd_data(cmd_data), .cmd_data_en(cmd_data_en), .cmd_quad(cmd_quad), .cmd_read(cmd_read),
    .wp_level(wp_level), .done(done), .rdata(rdata), .lnk(lnk));
  // Long operation so a suspend frame lands while it still runs
  fpr_dev #(.OP_CYCLES(200)) i_fpr_dev (.clk(clk), .resetn(resetn), .lnk(lnk),
    .status_reg(status_reg), .func_reg(func_reg), .op_start(op_start), .op_kind(op_kind),
    .op_refused(op_refused), .op_done(op_done));
  fpr_checker i_fpr_checker (.clk(clk), .resetn(resetn), .sck(lnk.sck), .cs_n(lnk.cs_n),
    .h_do(lnk.h_do), .h_oe(lnk.h_oe), .d_do(lnk.d_do), .d_oe(lnk.d_oe), .dq(lnk.dq));

  // ----------------------------------------------------------------
  // Clock and event counting
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  // Pulses are one cycle long, so each is counted once
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      n_st++;
      last_kind = op_kind;
    end
    if (op_refused === 1'b1) n_rf++;
    if (op_done === 1'b1) n_dn++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  // One framed command; returns once the device has had time to commit it
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic ae,
                      input logic de, input logic [7:0] d, input logic rd);
    int k;
    @(posedge clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_addr_en <= ae;
    cmd_data <= d;
    cmd_data_en <= de;
    cmd_read <= rd;
    cmd_valid <= 1'b1;
    @(posedge clk);
    chk("ready", 8'h01, {7'h00, cmd_ready});
    cmd_valid <= 1'b0;
    for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk);
    if (k == 2000) begin
      n_mismatch++;
      wrap_up();
    end
    repeat (8) @(posedge clk);
  endtask

  // Waits for the operation to end; the margin lets the event counters settle
  task automatic wait_idle();
    int k;
    for (k = 0; k < 2000 && status_reg[0] !== 1'b0; k++) @(posedge clk);
    if (k == 2000) begin
      n_mismatch++;
      wrap_up();
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic rd_chk();
    send(8'h05, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b1);
    chk("status_read", sr_m, rdata);
    send(8'h48, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b1);
    chk("func_read", fr_m, rdata);
    chk("status", sr_m, status_reg);
    chk("func", fr_m, func_reg);
    chk("refusals", e_rf[7:0], n_rf[7:0]);
    chk("starts", e_st[7:0], n_st[7:0]);
  endtask

  task automatic set_write_latch_cmd();
    send(8'h06, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b0);
    sr_m[1] = 1'b1;
    chk("latch_set", sr_m, status_reg);
  endtask

  // Latch is dropped after each status write and each prog call so a refused write leaves no doubt about it
  task automatic wrdi();
    send(8'h04, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b0);
    sr_m[1] = 1'b0;
  endtask

  task automatic status_write_cmd(input logic [7:0] d, input logic en, input logic wp);
    wp_level <= wp;
    if (en) set_write_latch_cmd();
    send(8'h01, 24'h000000, 1'b0, 1'b1, d, 1'b0);
    // With quad enable set the protect pin is data and cannot lock the status
    if (!en || (sr_m[7] && !sr_m[6] && !wp)) begin
      e_rf++;
    end else begin
      sr_m = {d[7:2], 2'b00};
      chk("latch_cleared", 8'h00, {7'h00, status_reg[1]});
    end
    chk("status_write", sr_m & 8'hfc, status_reg & 8'hfc);
    wrdi();
  endtask

  task automatic wrfr(input logic [7:0] d);
    set_write_latch_cmd();
    send(8'h42, 24'h000000, 1'b0, 1'b1, d, 1'b0);
    fr_m = fr_m | (d & 8'hf0);
    sr_m[1] = 1'b0;
    rd_chk();
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] a, input logic deny,
                      input logic we);
    logic [7:0] d;
    d = $random(seed);
    if (we) set_write_latch_cmd();
    send(op, a, 1'b1, op != 8'h20, d, 1'b0);
    if (deny) begin
      e_rf++;
    end else begin
      e_st++;
      wait_idle();
      sr_m[1] = 1'b0;
      chk("status_after_op", sr_m, status_reg);
      chk("op_kind", {7'h00, op == 8'h20}, {7'h00, last_kind});
      chk("dones", e_st[7:0], n_dn[7:0]);
    end
    wrdi();
    rd_chk();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic w;
    logic e;
    logic [3:0] code;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk();
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      w = $random(seed);
      e = $random(seed);
      status_write_cmd(v & 8'hbc, e, w);
      rd_chk();
    end
    status_write_cmd(8'h00, 1'b1, 1'b1);
    wrfr(8'h5f);
    wrfr(8'h00);
    prog(8'h62, 24'h000000, 1'b1, 1'b1);
    prog(8'h62, 24'h000100, 1'b0, 1'b1);
    prog(8'h02, 24'h000000, 1'b1, 1'b0);
    // Suspend and resume, both opcode forms, while the operation still runs
    for (int kk = 0; kk < 2; kk++) begin
      set_write_latch_cmd();
      send(kk ? 8'h20 : 8'h02, 24'h000000, 1'b1, !kk, 8'ha5, 1'b0);
      e_st++;
      send(kk ? 8'hb0 : 8'h75, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b0);
      fr_m[2 + kk] = 1'b1;
      chk("suspend_flag", fr_m, func_reg);
      send(kk ? 8'h30 : 8'h7a, 24'h000000, 1'b0, 1'b0, 8'h00, 1'b0);
      fr_m[2 + kk] = 1'b0;
      chk("resume_flag", fr_m, func_reg);
      wait_idle();
      sr_m[1] = 1'b0;
      rd_chk();
    end
    // Quad data phase: with quad enable set the protect pin is a data line
    status_write_cmd(8'hc0, 1'b1, 1'b0);
    cmd_quad <= 1'b1;
    prog(8'h32, 24'h000000, 1'b0, 1'b1);
    cmd_quad <= 1'b0;
    status_write_cmd(8'h00, 1'b1, 1'b0);
    // Block protect codes against every 32 KB block
    for (int c = 0; c < 6; c++) begin
      code = (c == 5) ? 4'hf : c[3:0];
      status_write_cmd({2'b00, code, 2'b00}, 1'b1, 1'b1);
      for (int b = 0; b < 4; b++) begin
        prog(b[0] ? 8'h20 : 8'h02, {7'h00, b[1:0], 15'h0000},
             code == 4'h0 ? 1'b0 : code == 4'h1 ? b == 3 : code == 4'h2 ? b >= 2 : 1'b1,
             1'b1);
      end
    end
    status_write_cmd(8'h00, 1'b1, 1'b1);
    wrap_up();
  end
endmodule

// ==== fpr_cfg.svh ====
// Constants for the flash protection and function-register link
`ifndef FPR_CFG_SVH
`define FPR_CFG_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FPR_OP_SET_WRITE_LATCH_CMD 8'h06
`define FPR_OP_WRDI 8'h04
`define FPR_OP_STATUS_WRITE_CMD 8'h01
`define FPR_OP_RDSR 8'h05
`define FPR_OP_WRFR 8'h42
`define FPR_OP_RDFR 8'h48
`define FPR_OP_PP 8'h02
`define FPR_OP_PPQ 8'h32
`define FPR_OP_SER 8'h20
`define FPR_OP_SER_ALT 8'hd7
`define FPR_OP_BE32 8'h52
`define FPR_OP_BE64 8'hd8
`define FPR_OP_CE 8'hc7
`define FPR_OP_CE_ALT 8'h60
`define FPR_OP_IRP 8'h62
`define FPR_OP_IRER 8'h64
`define FPR_OP_SUS 8'h75
`define FPR_OP_SUS_ALT 8'hb0
`define FPR_OP_RSM 8'h7a
`define FPR_OP_RSM_ALT 8'h30
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FPR_SR_STATUS_WRITE_DISABLE 7
`define FPR_SR_QE 6
`define FPR_SR_BP_LSB 2
`define FPR_SR_WEL 1
`define FPR_SR_WIP 0
`define FPR_FR_IRL_LSB 4
`define FPR_FR_ERASE_SUSPENDED_FLAG 3
`define FPR_FR_PROGRAM_SUSPENDED_FLAG 2
`define FPR_SR_RST 8'h00
`define FPR_FR_RST 8'h00
`define FPR_SYNC_RST 6'h2f
`define FPR_LANE_IDLE 8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPR_CLK_PERIOD_NS 50
`define FPR_LINK_PERIOD_NS 400
`define FPR_HALF_CYC (`FPR_LINK_PERIOD_NS / `FPR_CLK_PERIOD_NS / 2)
`define FPR_OP_CYCLES 64
`endif

// ==== fpr_checker.sv ====
// Concurrent checks on the serial link between host end and device end
module fpr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link signals
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_do,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_do,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] dq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [7:0] rise_cnt_ff;
  // Link clock rises in the current frame; saturates so a long frame cannot wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt_ff <= 8'h00;
    end else if (cs_n) begin
      rise_cnt_ff <= 8'h00;
    end else if ($rose(sck) && rise_cnt_ff != 8'hff) begin
      rise_cnt_ff <= rise_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SCK_IN_FRAME: assert property ($rose(sck) |-> !cs_n)
    else $error("link clock rose outside a frame");
  AST_SCK_HALF: assert property ($changed(sck) |=> $stable(sck) [*3])
    else $error("link clock half period too short");
  AST_DATA_STEADY: assert property ($rose(sck) |-> $stable(h_do) && $stable(h_oe))
    else $error("host data moved at a sampling edge");
  AST_FRAME_START: assert property ($fell(cs_n) |-> !sck && h_oe[0])
    else $error("frame opened without idle clock and driven lane");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt_ff >= 8'h08)
    else $error("frame closed before a whole opcode byte");
  AST_CS_CLEAN_END: assert property ($rose(cs_n) |-> !sck && !$past(sck, 3))
    else $error("select rose too soon after the last clock");
  AST_CS_GAP: assert property ($rose(cs_n) |=> cs_n [*3])
    else $error("select high gap too short");
  AST_DEV_LANE: assert property ((d_oe & 4'hd) == 4'h0 && (h_oe & d_oe) == 4'h0)
    else $error("device drove a wrong lane or fought the host");
  AST_DEV_TALK: assert property ($rose(d_oe[1]) |-> !cs_n)
    else $error("device started driving outside a frame");
  AST_HOLD_HIGH: assert property ((h_oe[3] && h_oe != 4'hf) |-> dq[3])
    else $error("hold line not high outside quad data");

  // Main scenarios reached
  cover property ($rose(d_oe[1]));
  cover property ($rose(cs_n) && rise_cnt_ff == 8'h28);
  cover property ($rose(cs_n) && rise_cnt_ff == 8'h10);
  cover property (h_oe == 4'hf);
endmodule

// ==== fpr_dev.sv ====
// Device end: instruction capture, write protection and function register
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`include "fpr_cfg.svh"
//
// Function
// - Function register: locks, suspend flags, reserved zero
// - Program suspend sets flag, resume clears
// - Erase suspend sets flag, resume clears
// - Suspend flags and reserved bits read-only
// - Locked info row refuses programming
// - Lock bits set once, never cleared
// - Disable bit plus low pin freezes status while quad enable is clear
// - Modifying instructions need write-enable latch set
// - Block-protect bits guard part or all
// - Codes: none, block 3, blocks 2-3, all
// - Opcode captured in 8-bit instruction register
// - Everything shifted most significant bit first
// - Data sampled on rising clock, select low
// - Opcode byte first, then address or data
// - Select rise ends and commits the sequence
// - Status write dropped under hardware protection
// - Program or erase to protected area refused
// - Quad enable turns control pins into data
module fpr_dev #(
  parameter int OP_CYCLES = `FPR_OP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  fpr_if.dev lnk,
  // Register view
  output logic [7:0] status_reg,
  output logic [7:0] func_reg,
  // Operation events
  output logic op_start,
  output logic op_kind,
  output logic op_refused,
  output logic op_done
);
  logic [5:0] sy1_ff, sy2_ff;
  logic sck_d_ff, cs_d_ff;
  logic [3:0] bc_ff;
  logic [7:0] sh_ff, op_ff, data_ff, out_ff;
  logic [2:0] idx_ff;
  logic [23:0] addr_ff;
  logic rd_ff;
  logic status_write_disable_ff, qe_ff, wel_ff;
  logic [3:0] bp_ff, irl_ff;
  logic program_suspended_flag_ff, erase_suspended_flag_ff;
  logic busy_ff, run_ff;
  fpr_pkg::fpr_kind_t kind_ff;
  logic [15:0] cnt_ff;
  logic start_ff, refuse_ff, done_ff;
  logic sck_rise, sck_fall, cs_low, cs_end, wp_n, quad_in, byte_done, fin;
  logic [3:0] dq_s, nxt_bc;
  logic [7:0] nxt_sh;
  logic is_prog, is_erase, is_ir, hw_prot, area_bad, can_start;
  logic set_wel, clr_wel, sr_wr, fr_wr, start, suspend, resume, refuse;

  // Protection map of the 1 Mb part with four 32 KB blocks
  function automatic logic blk_prot(input logic [3:0] bp, input logic [1:0] blk);
    case (bp)
      4'h0: blk_prot = 1'b0;
      4'h1: blk_prot = blk == 2'd3;
      4'h2: blk_prot = blk[1];
      default: blk_prot = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy1_ff <= `FPR_SYNC_RST;
      sy2_ff <= `FPR_SYNC_RST;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sy1_ff <= {lnk.cs_n, lnk.sck, lnk.dq};
      sy2_ff <= sy1_ff;
      sck_d_ff <= sy2_ff[4];
      cs_d_ff <= sy2_ff[5];
    end
  end

  assign dq_s = sy2_ff[3:0];
  assign cs_low = !sy2_ff[5];
  assign cs_end = sy2_ff[5] && !cs_d_ff;
  assign sck_rise = sy2_ff[4] && !sck_d_ff && cs_low;
  assign sck_fall = !sy2_ff[4] && sck_d_ff;
  // With quad enabled the protect pin is a data line and reads as released
  assign wp_n = qe_ff ? 1'b1 : dq_s[2];
  assign quad_in = qe_ff && op_ff == `FPR_OP_PPQ && idx_ff >= 3'd4;

  // Next shift value: one bit, or a nibble in quad data phase
  always_comb begin
    nxt_sh = quad_in ? {sh_ff[3:0], dq_s} : {sh_ff[6:0], dq_s[0]};
    nxt_bc = bc_ff + (quad_in ? 4'h4 : 4'h1);
  end
  assign byte_done = sck_rise && nxt_bc == 4'h8;

  // ----------------------------------------------------------------
  // Byte assembly
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bc_ff <= 4'h0;
      sh_ff <= 8'h00;
      idx_ff <= 3'h0;
    end else if (!cs_low) begin
      bc_ff <= 4'h0;
      idx_ff <= 3'h0;
    end else if (sck_rise) begin
      sh_ff <= nxt_sh;
      bc_ff <= byte_done ? 4'h0 : nxt_bc;
      if (byte_done && idx_ff != 3'h7) idx_ff <= idx_ff + 3'h1;
    end
  end

  // Opcode, address and first data byte; later data bytes are not kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_ff <= 8'h00;
      addr_ff <= 24'h0;
      data_ff <= 8'h00;
    end else if (byte_done) begin
      if (idx_ff == 3'd0) op_ff <= nxt_sh;
      if (idx_ff >= 3'd1 && idx_ff <= 3'd3) addr_ff <= {addr_ff[15:0], nxt_sh};
      if (idx_ff == 3'd1 || idx_ff == 3'd4) data_ff <= nxt_sh;
    end
  end

  // Register read-out on line 1, changed on falling clock, repeats the byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_ff <= 1'b0;
      out_ff <= 8'h00;
    end else if (!cs_low) begin
      rd_ff <= 1'b0;
    end else if (byte_done && idx_ff == 3'd0 &&
                 (nxt_sh == `FPR_OP_RDSR || nxt_sh == `FPR_OP_RDFR)) begin
      rd_ff <= 1'b1;
      // Loaded one place back: the fall that ends the opcode brings the MSB out
      out_ff <= nxt_sh == `FPR_OP_RDSR ? {status_reg[0], status_reg[7:1]}
                                       : {func_reg[0], func_reg[7:1]};
    end else if (rd_ff && sck_fall) begin
      out_ff <= {out_ff[6:0], out_ff[7]};
    end
  end

  // ----------------------------------------------------------------
  // Commit decode at select rise
  // ----------------------------------------------------------------
  always_comb begin
    is_prog = op_ff == `FPR_OP_PP || op_ff == `FPR_OP_PPQ || op_ff == `FPR_OP_IRP;
    is_erase = op_ff == `FPR_OP_SER || op_ff == `FPR_OP_SER_ALT || op_ff == `FPR_OP_BE32 ||
               op_ff == `FPR_OP_BE64 || op_ff == `FPR_OP_CE || op_ff == `FPR_OP_CE_ALT ||
               op_ff == `FPR_OP_IRER;
    is_ir = op_ff == `FPR_OP_IRP || op_ff == `FPR_OP_IRER;
    hw_prot = status_write_disable_ff && !wp_n;
    if (is_ir) area_bad = irl_ff[addr_ff[9:8]];
    else if (op_ff == `FPR_OP_CE || op_ff == `FPR_OP_CE_ALT) area_bad = bp_ff != 4'h0;
    else area_bad = blk_prot(bp_ff, addr_ff[16:15]);
    can_start = (is_prog && idx_ff >= 3'd5) || (is_erase && (idx_ff >= 3'd4 ||
                op_ff == `FPR_OP_CE || op_ff == `FPR_OP_CE_ALT));
    set_wel = 1'b0;
    clr_wel = 1'b0;
    sr_wr = 1'b0;
    fr_wr = 1'b0;
    start = 1'b0;
    suspend = 1'b0;
    resume = 1'b0;
    refuse = 1'b0;
    if (cs_end) begin
      case (op_ff)
        `FPR_OP_SET_WRITE_LATCH_CMD: set_wel = 1'b1;
        `FPR_OP_WRDI: clr_wel = 1'b1;
        `FPR_OP_STATUS_WRITE_CMD: begin
          sr_wr = wel_ff && !hw_prot && idx_ff >= 3'd2;
          refuse = !sr_wr;
        end
        `FPR_OP_WRFR: begin
          fr_wr = wel_ff && idx_ff >= 3'd2;
          refuse = !fr_wr;
        end
        // An operation ending this cycle must not leave a stale flag behind
        `FPR_OP_SUS, `FPR_OP_SUS_ALT: suspend = busy_ff && run_ff && cnt_ff != 16'h0;
        `FPR_OP_RSM, `FPR_OP_RSM_ALT: resume = program_suspended_flag_ff || erase_suspended_flag_ff;
        default: begin
          if (can_start) begin
            start = wel_ff && !busy_ff && !area_bad;
            refuse = !start;
          end
        end
      endcase
    end
  end
  assign fin = busy_ff && run_ff && cnt_ff == 16'h0;

  // ----------------------------------------------------------------
  // Status register: latch, protect bits, disable and quad enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {status_write_disable_ff, qe_ff, bp_ff} <= 6'(`FPR_SR_RST >> `FPR_SR_BP_LSB);
      wel_ff <= 1'b0;
    end else begin
      if (sr_wr) {status_write_disable_ff, qe_ff, bp_ff} <= data_ff[7:2];
      // Set wins if a completion lands in the same cycle as a new enable
      if (set_wel) wel_ff <= 1'b1;
      else if (clr_wel || sr_wr || fr_wr || fin) wel_ff <= 1'b0;
    end
  end

  // Lock bits only ever gain ones; low data bits are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irl_ff <= 4'(`FPR_FR_RST >> `FPR_FR_IRL_LSB);
    else if (fr_wr) irl_ff <= irl_ff | data_ff[7:4];
  end

  // ----------------------------------------------------------------
  // Operation timer with suspend and resume
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      run_ff <= 1'b0;
      kind_ff <= fpr_pkg::FPR_K_PROG;
      cnt_ff <= 16'h0;
    end else if (start) begin
      busy_ff <= 1'b1;
      run_ff <= 1'b1;
      kind_ff <= is_prog ? fpr_pkg::FPR_K_PROG : fpr_pkg::FPR_K_ERASE;
      cnt_ff <= 16'(OP_CYCLES - 1);
    end else if (fin) begin
      busy_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      if (suspend) run_ff <= 1'b0;
      else if (resume) run_ff <= 1'b1;
      if (run_ff && !suspend) cnt_ff <= cnt_ff - 16'h1;
    end
  end

  // Suspend flags follow only the suspend and resume instructions
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      program_suspended_flag_ff <= 1'b0;
      erase_suspended_flag_ff <= 1'b0;
    end else begin
      if (suspend && kind_ff == fpr_pkg::FPR_K_PROG) program_suspended_flag_ff <= 1'b1;
      else if (resume) program_suspended_flag_ff <= 1'b0;
      if (suspend && kind_ff == fpr_pkg::FPR_K_ERASE) erase_suspended_flag_ff <= 1'b1;
      else if (resume) erase_suspended_flag_ff <= 1'b0;
    end
  end

  // Event pulses for the user side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_ff <= 1'b0;
      refuse_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      start_ff <= start;
      refuse_ff <= refuse;
      done_ff <= fin;
    end
  end

  // Register views; flags and reserved bits have no write path
  assign status_reg = {status_write_disable_ff, qe_ff, bp_ff, wel_ff, busy_ff};
  assign func_reg = {irl_ff, erase_suspended_flag_ff, program_suspended_flag_ff, 2'b00};
  assign lnk.d_do = {2'b00, out_ff[7], 1'b0};
  assign lnk.d_oe = {2'b00, rd_ff && cs_low, 1'b0};
  assign op_start = start_ff;
  assign op_kind = kind_ff;
  assign op_refused = refuse_ff;
  assign op_done = done_ff;
endmodule

// ==== fpr_host.sv ====
// Host end: frames one instruction per command onto the serial link
`include "fpr_cfg.svh"
module fpr_host #(
  parameter int HALF = `FPR_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic cmd_addr_en,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_data_en,
  input wire logic cmd_quad,
  input wire logic cmd_read,
  input wire logic wp_level,
  // Results
  output logic done,
  output logic [7:0] rdata,
  // Link
  fpr_if.host lnk
);
  fpr_pkg::fpr_hstate_t st_ff;
  logic [7:0] div_ff;
  logic sck_ff, cs_n_ff, done_ff;
  logic [39:0] frame_ff;
  logic [5:0] cnt_ff, nsgl_ff, nq_ff, ntot_ff;
  logic [3:0] do_ff, oe_ff;
  logic [7:0] rdata_ff;
  logic [1:0] rsy_ff;
  logic tick;
  logic [5:0] prev;
  logic [39:0] nxt_frame;
  logic [7:0] nxt_lane;

  // Lane drive for clock j: {oe, do}; wp and hold pins held while not quad
  function automatic logic [7:0] lanes(input logic [5:0] j, input logic [5:0] ns,
                                       input logic [5:0] nq, input logic [39:0] f,
                                       input logic wp);
    if (j >= ns + nq) lanes = {4'b1100, 1'b1, wp, 2'b00};
    else if (j >= ns) lanes = {4'b1111, f[39:36]};
    else lanes = {4'b1101, 1'b1, wp, 1'b0, f[39]};
  endfunction

  assign tick = div_ff == 8'(HALF - 1);
  assign cmd_ready = st_ff == fpr_pkg::FPR_H_IDLE;
  assign prev = cnt_ff - 6'h1;
  // Shift by the width of the clock just finished, MSB first
  assign nxt_frame = (prev >= nsgl_ff && prev < nsgl_ff + nq_ff) ? {frame_ff[35:0], 4'h0}
                                                                   : {frame_ff[38:0], 1'b0};
  assign nxt_lane = lanes(cnt_ff, nsgl_ff, nq_ff, nxt_frame, wp_level);

  // ----------------------------------------------------------------
  // Read-back line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rsy_ff <= 2'b11;
    else rsy_ff <= {rsy_ff[0], lnk.dq[1]};
  end

  // Half-period divider, held at zero while idle, so each half is exactly HALF cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) div_ff <= 8'h00;
    else if (st_ff == fpr_pkg::FPR_H_IDLE || tick) div_ff <= 8'h00;
    else div_ff <= div_ff + 8'h1;
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= fpr_pkg::FPR_H_IDLE;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      done_ff <= 1'b0;
      frame_ff <= 40'h0;
      cnt_ff <= 6'h0;
      nsgl_ff <= 6'h0;
      nq_ff <= 6'h0;
      ntot_ff <= 6'h0;
      {oe_ff, do_ff} <= `FPR_LANE_IDLE;
      rdata_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        fpr_pkg::FPR_H_IDLE: begin
          {oe_ff, do_ff} <= {4'b1100, 1'b1, wp_level, 2'b00};
          if (cmd_valid) begin
            // One opcode byte first, then address and data as asked
            frame_ff <= cmd_addr_en ? {cmd_op, cmd_addr, cmd_data}
                                    : {cmd_op, cmd_data, 24'h0};
            nsgl_ff <= 6'd8 + (cmd_addr_en ? 6'd24 : 6'd0) +
                       ((cmd_data_en && !cmd_quad) ? 6'd8 : 6'd0);
            nq_ff <= (cmd_data_en && cmd_quad) ? 6'd2 : 6'd0;
            ntot_ff <= 6'd8 + (cmd_addr_en ? 6'd24 : 6'd0) + (cmd_data_en ?
                       (cmd_quad ? 6'd2 : 6'd8) : 6'd0) + (cmd_read ? 6'd8 : 6'd0);
            cnt_ff <= 6'h0;
            cs_n_ff <= 1'b0;
            {oe_ff, do_ff} <= {4'b1101, 1'b1, wp_level, 1'b0, cmd_op[7]};
            st_ff <= fpr_pkg::FPR_H_RUN;
          end
        end
        fpr_pkg::FPR_H_RUN: begin
          if (tick && !sck_ff) begin
            sck_ff <= 1'b1;
            cnt_ff <= cnt_ff + 6'h1;
          end else if (tick) begin
            sck_ff <= 1'b0;
            // Sample late in the high phase to cover the device's sync delay
            if (prev >= nsgl_ff + nq_ff) rdata_ff <= {rdata_ff[6:0], rsy_ff[1]};
            if (cnt_ff == ntot_ff) begin
              st_ff <= fpr_pkg::FPR_H_END;
            end else begin
              frame_ff <= nxt_frame;
              {oe_ff, do_ff} <= nxt_lane;
            end
          end
        end
        fpr_pkg::FPR_H_END: begin
          if (tick) begin
            cs_n_ff <= 1'b1;
            {oe_ff, do_ff} <= {4'b1100, 1'b1, wp_level, 2'b00};
            st_ff <= fpr_pkg::FPR_H_GAP;
          end
        end
        fpr_pkg::FPR_H_GAP: begin
          if (tick) begin
            done_ff <= 1'b1;
            st_ff <= fpr_pkg::FPR_H_IDLE;
          end
        end
        default: st_ff <= fpr_pkg::FPR_H_IDLE;
      endcase
    end
  end

  assign lnk.sck = sck_ff;
  assign lnk.cs_n = cs_n_ff;
  assign lnk.h_do = do_ff;
  assign lnk.h_oe = oe_ff;
  assign done = done_ff;
  assign rdata = rdata_ff;
endmodule

// ==== fpr_if.sv ====
// Serial link between host controller and flash device
interface fpr_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_do;
  logic [3:0] h_oe;
  logic [3:0] d_do;
  logic [3:0] d_oe;
  logic [3:0] dq;
  // Resolved data lines; an undriven line floats high through a pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq[i] = h_oe[i] ? h_do[i] : (d_oe[i] ? d_do[i] : 1'b1);
    end
  end
  modport host (output sck, output cs_n, output h_do, output h_oe, input dq);
  modport dev (input sck, input cs_n, input dq, output d_do, output d_oe);
endinterface

// ==== fpr_pkg.sv ====
// Types shared by both ends of the flash protection link
package fpr_pkg;
  // Kind of array operation in flight
  typedef enum logic {FPR_K_PROG, FPR_K_ERASE} fpr_kind_t;
  // Host sequencer states
  typedef enum logic [1:0] {FPR_H_IDLE, FPR_H_RUN, FPR_H_END, FPR_H_GAP} fpr_hstate_t;
endpackage
